/* verilog/pdm_pkg.sv */
/*
  Package for the pin drive-mode port: drive-mode codes, pin encodings,
  reset values and synchroniser depth.
  Assumes a single system clock and a synchronous active-high reset.
*/
package pdm_pkg;

  // Port width in pins.
  localparam int PDM_PINS = 8;

  // Drive-mode codes.
  typedef enum logic [2:0] {
    PDM_HIZ_ANALOG  = 3'h0,
    PDM_HIZ_DIGITAL = 3'h1,
    PDM_RES_PULLUP  = 3'h2,
    PDM_RES_PULLDN  = 3'h3,
    PDM_OD_LOW      = 3'h4,
    PDM_OD_HIGH     = 3'h5,
    PDM_STRONG      = 3'h6,
    PDM_RES_BOTH    = 3'h7
  } pdm_mode_t;

  // Per-pin driver encoding: strong high/low and resistive high/low.
  localparam int PDM_DRV_STRONG_HI = 0;
  localparam int PDM_DRV_STRONG_LO = 1;
  localparam int PDM_DRV_RES_HI    = 2;
  localparam int PDM_DRV_RES_LO    = 3;
  localparam int PDM_DRV_W         = 4;

  // Post-reset port state choices.
  localparam logic PDM_RST_PULLDN = 1'b0;
  localparam logic PDM_RST_PULLUP = 1'b1;

  // Reset value of the drive-mode bit registers: analog high impedance.
  localparam logic [PDM_PINS-1:0] PDM_DM_RESET = 8'h00;
  localparam logic [PDM_PINS-1:0] PDM_DR_RESET = 8'h00;

  // Synchroniser depth for pin inputs.
  localparam int PDM_SYNC_STAGES = 2;

endpackage

/* verilog/pdm_sync.sv */
/*
  Two-stage synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ns
module pdm_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous input and synchronised output.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import pdm_pkg::*;

  logic [WIDTH-1:0] stageOne;  // Read only by the second stage.

  //////////////////////////////////////////////////////////////////////////
  // Both stages clear on reset; the first feeds only the second.
  always_ff @(posedge clk) begin
    if (rst) begin
      stageOne <= '0;
      syncOut  <= '0;
    end else begin
      stageOne <= asyncIn;   // R20
      syncOut  <= stageOne;  // R20
    end
  end
endmodule

/* verilog/pdm_driver.sv */
/*
  Combinational decode of one pin's drive mode and output value into
  driver controls.
  Assumes the caller registers the result before it reaches a pin.
*/
`timescale 1ns/1ns
module pdm_driver (
  // Mode and data.
  input  wire pdm_pkg::pdm_mode_t          mode,
  input  wire logic                        outVal,
  // Driver controls.
  output logic [pdm_pkg::PDM_DRV_W-1:0]    drv
);
  import pdm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // One-hot style driver control; all zero is high impedance.
  always_comb begin
    drv = '0;
    case (mode)
      PDM_HIZ_ANALOG, PDM_HIZ_DIGITAL: begin
        drv = '0;  // R1
      end
      PDM_RES_PULLUP: begin
        drv[PDM_DRV_RES_HI]    = outVal;   // R2
        drv[PDM_DRV_STRONG_LO] = !outVal;  // R2
      end
      PDM_RES_PULLDN: begin
        drv[PDM_DRV_STRONG_HI] = outVal;   // R3
        drv[PDM_DRV_RES_LO]    = !outVal;  // R3
      end
      PDM_OD_LOW: begin
        drv[PDM_DRV_STRONG_LO] = !outVal;  // R4
      end
      PDM_OD_HIGH: begin
        drv[PDM_DRV_STRONG_HI] = outVal;   // R5
      end
      PDM_STRONG: begin
        drv[PDM_DRV_STRONG_HI] = outVal;   // R6
        drv[PDM_DRV_STRONG_LO] = !outVal;  // R6
      end
      default: begin
        drv[PDM_DRV_RES_HI] = outVal;      // R7
        drv[PDM_DRV_RES_LO] = !outVal;     // R7
      end
    endcase
  end
endmodule

/* verilog/pdm_port.sv */
/*
  Drive-mode and reset configuration of one I/O port.
  Holds three drive-mode bit registers and the output value register,
  picks the pin's output source, decodes the driver controls, samples the
  pins, and keeps the special-pin comparator settings.
  Assumes the stored reset configuration is presented steadily on
  nvResetEn and nvResetPullup, and that software honours the over-voltage mode limit.
*/
// Contract
// R1 - Codes 0 and 1 give high impedance
// R2 - Code 2: resistive high, strong low
// R3 - Code 3: strong high, resistive low
// R4 - Code 4: float high, strong low
// R5 - Code 5: strong high, float low
// R6 - Code 6: strong high and strong low
// R7 - Code 7: resistive high and resistive low
// R8 - Special pin pair shares one threshold
// R9 - Threshold may come from analog global
// R10 - Special pin input hysteresis is selectable
// R11 - Over-voltage special pins use codes 0,1,4; the port accepts any code, leaving the limit to software
// R12 - Reset holds all pins analog high-Z
// R13 - Reset release loads stored reset configuration
// R14 - Post-reset port state pull-up or pull-down
// R15 - Pins keep drive state in low power
// R16 - Pin interrupts keep running in low power
// R17 - Three per-port drive-mode bit registers
// R18 - Output from interconnect or output register
// R19 - Input feeds state register and interconnect
// R20 - Pin input passes two-stage synchroniser
`timescale 1ns/1ns
module pdm_port
  import pdm_pkg::*;
#(
  parameter int PINS = PDM_PINS
) (
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst,
  // Software writes of the drive-mode bit registers and output value.
  input  wire logic            wrDmBit2,
  input  wire logic            wrDmBit1,
  input  wire logic            wrDmBit0,
  input  wire logic            wrOutValue,
  input  wire logic [PINS-1:0] wrData,
  // Stored reset configuration and its post-reset state choice.
  input  wire logic            nvResetEn,
  input  wire logic            nvResetPullup,
  // Interconnect output path.
  input  wire logic [PINS-1:0] hwOutSel,
  input  wire logic [PINS-1:0] hwOutVal,
  // Interconnect input path enable.
  input  wire logic [PINS-1:0] hwInEn,
  // Low-power mode indication.
  input  wire logic            lowPower,
  // Interrupt enable per pin (edge of either polarity).
  input  wire logic [PINS-1:0] irqEn,
  // Special pin comparator configuration for the pair.
  input  wire logic            sioRefGlobal,
  input  wire logic            sioHystEn,
  input  wire logic [7:0]      sioRefLevel,
  // Pin inputs.
  input  wire logic [PINS-1:0] pinIn,
  // Pin driver controls.
  output logic [PINS-1:0]      pinStrongHi,
  output logic [PINS-1:0]      pinStrongLo,
  output logic [PINS-1:0]      pinResHi,
  output logic [PINS-1:0]      pinResLo,
  // Software view.
  output logic [PINS-1:0]      port_drive_mode_bit2,
  output logic [PINS-1:0]      port_drive_mode_bit1,
  output logic [PINS-1:0]      port_drive_mode_bit0,
  output logic [PINS-1:0]      port_output_value,
  output logic [PINS-1:0]      pinState,
  output logic [PINS-1:0]      hwInVal,
  output logic                 cfgLoaded,
  // Pin interrupt and wake.
  output logic                 pinIrq,
  output logic                 wakeReq,
  // Special pin comparator settings for the analog side.
  output logic                 sioUseGlobal,
  output logic                 sioHyst,
  output logic [7:0]           sioThreshold
);

  //////////////////////////////////////////////////////////////////////////
  // State.

  logic [PINS-1:0] next_port_drive_mode_bit2;  // Mode bit 2 per pin.
  logic [PINS-1:0] next_port_drive_mode_bit1;  // Mode bit 1 per pin.
  logic [PINS-1:0] next_port_drive_mode_bit0;  // Mode bit 0 per pin.
  logic [PINS-1:0] next_port_output_value;     // Output value register.
  logic            inReset;                    // Last cycle was reset.
  logic            next_cfgLoaded;             // Stored config applied.
  logic [PINS-1:0] syncIn;                     // Synchronised pins.
  logic [PINS-1:0] prevState;                  // For edge detection.
  logic [PINS-1:0] drvOut;                     // Value to the driver.
  logic [PINS-1:0] next_hi;
  logic [PINS-1:0] next_lo;
  logic [PINS-1:0] next_rhi;
  logic [PINS-1:0] next_rlo;
  logic            next_irq;

  // Mode of one pin assembled from the three bit registers.
  function automatic pdm_mode_t pinMode(input int idx,
      input logic [PINS-1:0] b2, input logic [PINS-1:0] b1,
      input logic [PINS-1:0] b0);
    pinMode = pdm_mode_t'({b2[idx], b1[idx], b0[idx]});  // R17
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser.
  pdm_sync #(
    .WIDTH (PINS)
  ) uSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (pinIn),
    .syncOut (syncIn)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output source: interconnect when connected, else the register.
  always_comb begin
    drvOut = (hwOutSel & hwOutVal) | (~hwOutSel & port_output_value);  // R18
  end

  // Driver decode per pin.
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gDrv
      logic [PDM_DRV_W-1:0] drv;
      pdm_driver uDrv (
        .mode   (pinMode(g, port_drive_mode_bit2, port_drive_mode_bit1,
                         port_drive_mode_bit0)),
        .outVal (drvOut[g]),
        .drv    (drv)
      );
      assign next_hi[g]  = drv[PDM_DRV_STRONG_HI];
      assign next_lo[g]  = drv[PDM_DRV_STRONG_LO];
      assign next_rhi[g] = drv[PDM_DRV_RES_HI];
      assign next_rlo[g] = drv[PDM_DRV_RES_LO];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers. The stored reset data is applied once, on the
  // first cycle after release, the first cycle a software write can land; a
  // software write in that same cycle wins since it is the newer intent.
  always_comb begin
    next_port_drive_mode_bit2 = port_drive_mode_bit2;
    next_port_drive_mode_bit1 = port_drive_mode_bit1;
    next_port_drive_mode_bit0 = port_drive_mode_bit0;
    next_port_output_value    = port_output_value;
    next_cfgLoaded            = cfgLoaded;
    if (inReset) begin
      next_cfgLoaded = 1'b1;  // R13
      if (nvResetEn) begin
        // Resistive pull-up/down with the output value fixing the way.
        next_port_drive_mode_bit2 = {PINS{1'b0}};  // R14
        next_port_drive_mode_bit1 = {PINS{1'b1}};  // R14
        next_port_drive_mode_bit0 = {PINS{nvResetPullup == PDM_RST_PULLDN}};
        next_port_output_value    = {PINS{nvResetPullup}};  // R13
      end
    end
    // Writes are plain register stores; low power never disturbs them.
    if (wrDmBit2) begin
      next_port_drive_mode_bit2 = wrData;  // R17
    end
    if (wrDmBit1) begin
      next_port_drive_mode_bit1 = wrData;  // R17
    end
    if (wrDmBit0) begin
      next_port_drive_mode_bit0 = wrData;  // R17
    end
    if (wrOutValue) begin
      next_port_output_value = wrData;
    end
  end

  // Registers only; reset forces analog high impedance.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_drive_mode_bit2 <= PDM_DM_RESET;  // R12
      port_drive_mode_bit1 <= PDM_DM_RESET;  // R12
      port_drive_mode_bit0 <= PDM_DM_RESET;  // R12
      port_output_value    <= PDM_DR_RESET;
      cfgLoaded            <= 1'b0;
      inReset              <= 1'b1;
    end else begin
      port_drive_mode_bit2 <= next_port_drive_mode_bit2;
      port_drive_mode_bit1 <= next_port_drive_mode_bit1;
      port_drive_mode_bit0 <= next_port_drive_mode_bit0;
      port_output_value    <= next_port_output_value;
      cfgLoaded            <= next_cfgLoaded;
      inReset              <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Driver outputs; held in their state through low power since nothing
  // here depends on lowPower. Reset drives them all off.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinStrongHi <= '0;  // R12
      pinStrongLo <= '0;  // R12
      pinResHi    <= '0;  // R12
      pinResLo    <= '0;  // R12
    end else begin
      pinStrongHi <= next_hi;   // R15
      pinStrongLo <= next_lo;   // R15
      pinResHi    <= next_rhi;  // R15
      pinResLo    <= next_rlo;  // R15
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input side and pin interrupt. The interrupt stays live in low power so
  // that a pin change can wake the device.
  always_comb begin
    next_irq = |((syncIn ^ prevState) & irqEn);  // R16
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinState  <= '0;
      prevState <= '0;
      hwInVal   <= '0;
      pinIrq    <= 1'b0;
      wakeReq   <= 1'b0;
    end else begin
      pinState  <= syncIn;           // R19
      prevState <= syncIn;
      hwInVal   <= syncIn & hwInEn;  // R19
      pinIrq    <= next_irq;         // R16
      wakeReq   <= next_irq & lowPower;  // R16
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Special pin pair: one threshold for both pins, optional analog global
  // source, and a hysteresis enable passed to the input buffer.
  always_ff @(posedge clk) begin
    if (rst) begin
      sioUseGlobal <= 1'b0;
      sioHyst      <= 1'b0;
      sioThreshold <= 8'h00;
    end else begin
      sioUseGlobal <= sioRefGlobal;  // R9
      sioHyst      <= sioHystEn;     // R10
      sioThreshold <= sioRefLevel;   // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  strong_drive_a: assert property (@(posedge clk) disable iff (rst)
    (port_drive_mode_bit2 == '1 && port_drive_mode_bit1 == '1 &&
     port_drive_mode_bit0 == '0 && !$changed(drvOut))
    |=> (pinStrongHi == $past(drvOut) && pinStrongLo == ~$past(drvOut)))
    else $error("strong mode drive mismatch");  // R6

  hiz_mode_a: assert property (@(posedge clk) disable iff (rst)
    (port_drive_mode_bit2 == '0 && port_drive_mode_bit1 == '0)
    |=> (pinStrongHi == '0 && pinResLo == '0 && pinResHi == '0 &&
         pinStrongLo == '0))
    else $error("high impedance mode drives pin");  // R1

  reset_hold_a: assert property (@(posedge clk)
    rst |=> (pinStrongHi == '0 && pinStrongLo == '0 && !cfgLoaded))
    else $error("pin driven after reset");  // R12

  cfg_load_a: assert property (@(posedge clk)
    ($fell(rst) && nvResetEn && !wrOutValue)
    |=> (cfgLoaded && port_output_value == {PINS{$past(nvResetPullup)}}))
    else $error("reset configuration not loaded");  // R13

  sync_delay_a: assert property (@(posedge clk) disable iff (rst)
    1 |-> ##3 (pinState == $past(pinIn, 3)))
    else $error("pin state not three cycles behind");  // R20

  hw_in_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (hwInVal == (pinState & $past(hwInEn))))
    else $error("interconnect input mismatch");  // R19

  wake_a: assert property (@(posedge clk) disable iff (rst)
    (next_irq && lowPower) |=> (pinIrq && wakeReq))
    else $error("pin interrupt lost in low power");  // R16

  od_low_a: assert property (@(posedge clk) disable iff (rst)
    (port_drive_mode_bit2 == '1 && port_drive_mode_bit1 == '0 &&
     port_drive_mode_bit0 == '0) |=> (pinStrongHi == '0 && pinResHi == '0))
    else $error("open drain low drives high");  // R4

endmodule

/* sim/pdm_pin_load.sv */
/*
  Board-side model of the pins of one port: resolves the port's driver
  controls and an external resistor level into the level seen on each pin.
  Assumes the four driver vectors come straight from the port outputs.
*/
`timescale 1ns/1ns
module pdm_pin_load #(
  parameter int PINS = 8
) (
  // Driver controls from the port.
  input  wire logic [PINS-1:0] strongHi,
  input  wire logic [PINS-1:0] strongLo,
  input  wire logic [PINS-1:0] resHi,
  input  wire logic [PINS-1:0] resLo,
  // Level that a board resistor gives a pin which nothing drives.
  input  wire logic [PINS-1:0] extLvl,
  // Resolved pin levels.
  output logic      [PINS-1:0] pinIn
);
  //////////////////////////////////////////////////////////////////////////
  // Strong drive beats resistive drive, which beats the board resistor.
  // A floating pin takes the resistor level, never its last value.
  // The board never lifts a pin above its own supply, so the special-pin
  // mode limit for over-voltage never comes into play here.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (strongHi[i] || strongLo[i]) begin
        pinIn[i] = strongHi[i];
      end else if (resHi[i] || resLo[i]) begin
        pinIn[i] = resHi[i];
      end else begin
        pinIn[i] = extLvl[i];
      end
    end
  end
endmodule

/* sim/test_pin_drive_mode_and_reset_config.sv */
/*
  Self-checking bench for the drive-mode port: mode table, reset load,
  output source, input path, interrupts in low power and comparator setup.
  Assumes pdm_pkg and the board load model are compiled before it.
*/
`timescale 1ns/1ns
module test_pin_drive_mode_and_reset_config;
  import pdm_pkg::*;
  // Clock, reset and write strobes {bit2, bit1, bit0, value}.
  logic       clk = 1'b0;
  logic       rst, nvResetEn, nvResetPullup, lowPower;
  logic       sioRefGlobal, sioHystEn, cfgLoaded, pinIrq, wakeReq;
  logic       sioUseGlobal, sioHyst;
  logic [3:0] wrStb;
  // Port-wide vectors.
  logic [7:0] wrData, hwOutSel, hwOutVal, hwInEn, irqEn, sioRefLevel;
  logic [7:0] extLvl, pinIn, sHi, sLo, rHi, rLo, dm2, dm1, dm0, outV;
  logic [7:0] pinState, hwInVal, sioThr;
  int         n_fail = 0;
  int         cmp_count = 0;
  // Row: {mode, output value, expected {strongHi, strongLo, resHi, resLo}}.
  localparam logic [7:0] ROWS [16] = '{8'h00, 8'h10, 8'h20, 8'h30,
    8'h44, 8'h52, 8'h61, 8'h78, 8'h84, 8'h90, 8'hA0, 8'hB8, 8'hC4, 8'hD8,
    8'hE1, 8'hF2};

  always #2 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  pdm_port #(.PINS(8)) pdm_port_inst (.clk(clk), .rst(rst),
    .wrDmBit2(wrStb[3]), .wrDmBit1(wrStb[2]), .wrDmBit0(wrStb[1]),
    .wrOutValue(wrStb[0]), .wrData(wrData), .nvResetEn(nvResetEn),
    .nvResetPullup(nvResetPullup), .hwOutSel(hwOutSel),
    .hwOutVal(hwOutVal), .hwInEn(hwInEn), .lowPower(lowPower),
    .irqEn(irqEn), .sioRefGlobal(sioRefGlobal), .sioHystEn(sioHystEn),
    .sioRefLevel(sioRefLevel), .pinIn(pinIn), .pinStrongHi(sHi),
    .pinStrongLo(sLo), .pinResHi(rHi), .pinResLo(rLo),
    .port_drive_mode_bit2(dm2), .port_drive_mode_bit1(dm1),
    .port_drive_mode_bit0(dm0), .port_output_value(outV),
    .pinState(pinState), .hwInVal(hwInVal), .cfgLoaded(cfgLoaded),
    .pinIrq(pinIrq), .wakeReq(wakeReq), .sioUseGlobal(sioUseGlobal),
    .sioHyst(sioHyst), .sioThreshold(sioThr));

  pdm_pin_load #(.PINS(8)) pdm_pin_load_inst (.strongHi(sHi),
    .strongLo(sLo), .resHi(rHi), .resLo(rLo), .extLvl(extLvl),
    .pinIn(pinIn));

  //////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write cycle; the next call replaces the strobes, so no strobe is
  // assigned twice in one time step.
  task automatic wr(input logic [3:0] stb, input logic [7:0] d);
    wrStb = stb;
    wrData = d;
    @(posedge clk);
    #1;
  endtask

  // Let n edges pass, then step past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Put every pin in one mode and value; drivers have settled on return.
  task automatic setAll(input logic [2:0] m, input logic v);
    wr(4'b1000, {8{m[2]}});
    wr(4'b0100, {8{m[1]}});
    wr(4'b0010, {8{m[0]}});
    wr(4'b0001, {8{v}});
    wr(4'b0000, 8'h00);
  endtask

  // Print the verdict and stop.
  task automatic conclude;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // The tests need about 126 cycles; about eight times that cuts off a hang.
  initial begin
    #4000;
    n_fail++;
    conclude;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    wrStb = 4'b0000;
    wrData = 8'h00;
    nvResetEn = 1'b1;
    nvResetPullup = PDM_RST_PULLUP;
    hwOutSel = 8'h00;
    hwOutVal = 8'h00;
    hwInEn = 8'h0F;
    lowPower = 1'b0;
    irqEn = 8'hFF;
    sioRefGlobal = 1'b0;
    sioHystEn = 1'b0;
    sioRefLevel = 8'h00;
    extLvl = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    chk(sHi | sLo | rHi | rLo, 8'h00);
    rst = 1'b0;
    // Stored pull-up configuration lands at the first edge after release.
    tick(1);
    chk({7'h00, cfgLoaded}, 8'h01);
    chk(dm1 & ~dm2 & ~dm0, 8'hFF);
    chk(outV, 8'hFF);
    tick(1);
    chk(rHi, 8'hFF);
    // Every mode with both output values.
    for (int i = 0; i < 16; i++) begin
      setAll(ROWS[i][7:5], ROWS[i][4]);
      chk(dm2, {8{ROWS[i][7]}});
      chk(sHi, {8{ROWS[i][3]}});
      chk(sLo, {8{ROWS[i][2]}});
      chk(rHi, {8{ROWS[i][1]}});
      chk(rLo, {8{ROWS[i][0]}});
    end
    // Low nibble takes the interconnect value, high nibble the register.
    hwOutSel = 8'h0F;
    hwOutVal = 8'h55;
    setAll(3'h6, 1'b0);
    chk(sHi, 8'h05);
    chk(sLo, 8'hFA);
    hwOutSel = 8'h00;
    // Drive state holds through low power.
    setAll(3'h6, 1'b1);
    lowPower = 1'b1;
    tick(3);
    chk(sHi, 8'hFF);
    // Float the pins, let the edge from floating pass, then raise them.
    setAll(3'h0, 1'b0);
    tick(6);
    extLvl = 8'hFF;
    tick(3);
    chk(pinState, 8'hFF);
    chk(hwInVal, 8'h0F);
    // The edge detector compares against the previous synchronised value,
    // so the interrupt pulse stands in the same cycle as the new state.
    chk({6'h00, pinIrq, wakeReq}, 8'h03);
    tick(1);
    chk({6'h00, pinIrq, wakeReq}, 8'h00);
    tick(1);
    chk({6'h00, pinIrq, wakeReq}, 8'h00);
    // Awake: a falling edge interrupts but does not ask for wake-up.
    lowPower = 1'b0;
    extLvl = 8'h00;
    tick(3);
    chk({6'h00, pinIrq, wakeReq}, 8'h02);
    // One threshold for the pair, from the global line, with hysteresis.
    sioRefGlobal = 1'b1;
    sioHystEn = 1'b1;
    sioRefLevel = 8'hA5;
    tick(1);
    chk(sioThr, 8'hA5);
    chk({6'h00, sioUseGlobal, sioHyst}, 8'h03);
    // Reset in mid-run with a stored pull-down choice.
    setAll(3'h6, 1'b1);
    rst = 1'b1;
    nvResetPullup = PDM_RST_PULLDN;
    tick(1);
    chk(sHi | sLo | rHi | rLo, 8'h00);
    rst = 1'b0;
    tick(1);
    chk(dm1 & dm0 & ~dm2, 8'hFF);
    tick(1);
    chk(rLo, 8'hFF);
    conclude;
  end
endmodule
